// >>> common/clcr_params.svh
// Offsets, field positions, reset values and scale constants of the limit and compensation registers
`ifndef CLCR_PARAMS_SVH
`define CLCR_PARAMS_SVH
`define CLCR_ADDR_W 8
`define CLCR_OFS_LIMIT 8'h05
`define CLCR_OFS_LOOP 8'h06
`define CLCR_RST_LIMIT 8'h00
`define CLCR_RST_LOOP 8'h00
`define CLCR_BIT_FCCM 7
`define CLCR_BIT_REV 6
`define CLCR_VAL_HI 5
`define CLCR_VAL_LO 3
`define CLCR_PK_HI 2
`define CLCR_PK_LO 0
`define CLCR_FB_HI 7
`define CLCR_FB_LO 5
`define CLCR_RC_HI 4
`define CLCR_RC_LO 0
`define CLCR_VAL_BASE_A 4'h1
`define CLCR_PK_BASE_A 4'h2
`define CLCR_FB_BASE_K 10'h032
`define CLCR_FB_STEP_K 10'h01e
`define CLCR_REV_LO_DA 6'h19
`define CLCR_REV_HI_DA 6'h2f
`endif

// >>> common/clcr_pkg.sv
// Types shared by the limit and compensation register block
package clcr_pkg;
	typedef struct packed {
		logic forced_continuous_sel;
		logic reverse_limit_sel;
		logic [2:0] valley_limit_code;
		logic [2:0] peak_limit_code;
	} clcr_limit_t;
	typedef struct packed {
		logic [2:0] feedback_resistor_code;
		logic [4:0] loop_resistor_code;
	} clcr_loop_t;
	typedef struct packed {
		logic forced_continuous;
		logic reverse_limit_en;
		logic [5:0] reverse_limit_da;
		logic valley_limit_valid;
		logic [3:0] valley_limit_a;
		logic [3:0] peak_limit_a;
		logic [9:0] feedback_res_k;
		logic [11:0] loop_res_k;
	} clcr_ctrl_t;
endpackage

// >>> hdl/clcr_rcomp_lut.sv
// Compensation resistor code to kilohm lookup
`timescale 1ns/1ps
`include "clcr_params.svh"
module clcr_rcomp_lut
(
	// Code in
	input wire logic [4:0] code,
	// Resistance out
	output logic [11:0] res_k
);
	// Fixed table, steps are uneven so no formula fits
	always_comb
	begin
		unique case (code)
			5'h00: res_k = 12'd50;
			5'h01: res_k = 12'd173;
			5'h02: res_k = 12'd297;
			5'h03: res_k = 12'd420;
			5'h04: res_k = 12'd544;
			5'h05: res_k = 12'd667;
			5'h06: res_k = 12'd791;
			5'h07: res_k = 12'd914;
			5'h08: res_k = 12'd1038;
			5'h09: res_k = 12'd1161;
			5'h0a: res_k = 12'd1284;
			5'h0b: res_k = 12'd1408;
			5'h0c: res_k = 12'd1531;
			5'h0d: res_k = 12'd1655;
			5'h0e: res_k = 12'd1778;
			5'h0f: res_k = 12'd1902;
			5'h10: res_k = 12'd2025;
			5'h11: res_k = 12'd2148;
			5'h12: res_k = 12'd2272;
			5'h13: res_k = 12'd2395;
			5'h14: res_k = 12'd2519;
			5'h15: res_k = 12'd2642;
			5'h16: res_k = 12'd2766;
			5'h17: res_k = 12'd2889;
			5'h18: res_k = 12'd3012;
			5'h19: res_k = 12'd3136;
			5'h1a: res_k = 12'd3259;
			5'h1b: res_k = 12'd3383;
			5'h1c: res_k = 12'd3506;
			5'h1d: res_k = 12'd3630;
			5'h1e: res_k = 12'd3753;
			5'h1f: res_k = 12'd3877;
		endcase
	end
endmodule

// >>> hdl/clcr_regs.sv
// Current limit, conduction mode and loop resistor register pair
`timescale 1ns/1ps
`include "clcr_params.svh"
module clcr_regs
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Register access from the serial management logic, same clock
	input wire logic [`CLCR_ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic reg_hit,
	// Raw fields
	output clcr_pkg::clcr_limit_t limit_fields,
	output clcr_pkg::clcr_loop_t loop_fields,
	// Decoded settings for the analog side
	output clcr_pkg::clcr_ctrl_t ctrl
);
	// Reset values split into fields once, so each field flop reads its own slice
	localparam clcr_pkg::clcr_limit_t LIMIT_RST = `CLCR_RST_LIMIT;
	localparam clcr_pkg::clcr_loop_t LOOP_RST = `CLCR_RST_LOOP;

	// Reset synchroniser
	logic rst_meta_r;
	logic rst_sync_r;
	logic rst_n;
	// Address decode and write strobes
	logic hit_limit;
	logic hit_loop;
	logic wr_limit;
	logic wr_loop;
	// Register fields, one flop group per field
	logic fccm_r;
	logic rev_sel_r;
	logic [2:0] valley_code_r;
	logic [2:0] peak_code_r;
	logic [2:0] fb_code_r;
	logic [4:0] rcomp_code_r;
	clcr_pkg::clcr_limit_t limit_word;
	clcr_pkg::clcr_loop_t loop_word;
	// Read path
	logic [7:0] rdata_nxt;
	// Decode, combinational part
	logic [11:0] rcomp_k;
	logic [3:0] valley_a;
	logic [3:0] peak_a;
	logic [5:0] rev_da_nxt;
	logic [9:0] fb_k_nxt;
	// Decode, registered part
	logic mode_fccm_r;
	logic rev_en_r;
	logic [5:0] rev_da_r;
	logic valley_ok_r;
	logic [3:0] valley_a_r;
	logic [3:0] peak_a_r;
	logic [9:0] fb_k_r;
	logic [11:0] rcomp_k_r;

	// Reset release through two flops so deassertion is clean
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end
	assign rst_n = rst_sync_r;

	// Address decode shared by write, read and hit
	assign hit_limit = (reg_addr == `CLCR_OFS_LIMIT);
	assign hit_loop = (reg_addr == `CLCR_OFS_LOOP);
	// Unmapped offsets never raise a write strobe
	assign wr_limit = reg_wr && hit_limit;
	assign wr_loop = reg_wr && hit_loop;

	// Conduction mode bit
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			fccm_r <= LIMIT_RST.forced_continuous_sel;
		else if (wr_limit)
			fccm_r <= reg_wdata[`CLCR_BIT_FCCM];
	end

	// Reverse limit select, kept even in DCM so a later mode switch finds it
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			rev_sel_r <= LIMIT_RST.reverse_limit_sel;
		else if (wr_limit)
			rev_sel_r <= reg_wdata[`CLCR_BIT_REV];
	end

	// Valley limit code
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			valley_code_r <= LIMIT_RST.valley_limit_code;
		else if (wr_limit)
			valley_code_r <= reg_wdata[`CLCR_VAL_HI:`CLCR_VAL_LO];
	end

	// Peak limit code
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			peak_code_r <= LIMIT_RST.peak_limit_code;
		else if (wr_limit)
			peak_code_r <= reg_wdata[`CLCR_PK_HI:`CLCR_PK_LO];
	end

	// Feedback resistor code
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			fb_code_r <= LOOP_RST.feedback_resistor_code;
		else if (wr_loop)
			fb_code_r <= reg_wdata[`CLCR_FB_HI:`CLCR_FB_LO];
	end

	// Loop resistor code
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			rcomp_code_r <= LOOP_RST.loop_resistor_code;
		else if (wr_loop)
			rcomp_code_r <= reg_wdata[`CLCR_RC_HI:`CLCR_RC_LO];
	end

	// One strobe per register, so every field of a byte lands in the same edge
	assign limit_word = {fccm_r, rev_sel_r, valley_code_r, peak_code_r};
	assign loop_word = {fb_code_r, rcomp_code_r};

	// Read mux; unmapped offsets read zero
	always_comb
	begin
		rdata_nxt = 8'h00;
		if (hit_limit)
			rdata_nxt = limit_word;
		else if (hit_loop)
			rdata_nxt = loop_word;
	end

	// Read data registered, one cycle after the strobe; holds between reads
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= rdata_nxt;
	end

	// Address hit flag, combinational handshake
	assign reg_hit = hit_limit || hit_loop;

	// Table lookup kept separate; it is pure constant logic
	clcr_rcomp_lut u_lut
	(
		.code(rcomp_code_r),
		.res_k(rcomp_k)
	);

	// Current scales, codes offset by a fixed amp base
	assign valley_a = {1'b0, valley_code_r} + `CLCR_VAL_BASE_A;
	assign peak_a = {1'b0, peak_code_r} + `CLCR_PK_BASE_A;

	// Reverse magnitude in tenths of an amp; DCM forces zero so no stale select leaks
	always_comb
	begin
		rev_da_nxt = 6'h00;
		if (fccm_r)
			rev_da_nxt = rev_sel_r ? `CLCR_REV_HI_DA : `CLCR_REV_LO_DA;
	end

	// Feedback resistor; largest code still fits ten bits
	assign fb_k_nxt = `CLCR_FB_BASE_K + 10'(fb_code_r * `CLCR_FB_STEP_K);

	// Mode and reverse limit stage
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mode_fccm_r <= 1'b0;
			rev_en_r <= 1'b0;
			rev_da_r <= 6'h00;
		end
		else
		begin
			mode_fccm_r <= fccm_r;
			rev_en_r <= fccm_r;
			rev_da_r <= rev_da_nxt;
		end
	end

	// Current limit stage; equal valley and peak still count as valid
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			valley_a_r <= 4'h0;
			valley_ok_r <= 1'b0;
			peak_a_r <= 4'h0;
		end
		else
		begin
			valley_a_r <= valley_a;
			valley_ok_r <= (valley_a <= peak_a);
			peak_a_r <= peak_a;
		end
	end

	// Resistor stage
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fb_k_r <= 10'h000;
			rcomp_k_r <= 12'h000;
		end
		else
		begin
			fb_k_r <= fb_k_nxt;
			rcomp_k_r <= rcomp_k;
		end
	end

	// Decoded outputs, one cycle behind the registers
	always_comb
	begin
		ctrl.forced_continuous = mode_fccm_r;
		ctrl.reverse_limit_en = rev_en_r;
		ctrl.reverse_limit_da = rev_da_r;
		ctrl.valley_limit_valid = valley_ok_r;
		ctrl.valley_limit_a = valley_a_r;
		ctrl.peak_limit_a = peak_a_r;
		ctrl.feedback_res_k = fb_k_r;
		ctrl.loop_res_k = rcomp_k_r;
	end

	// Raw fields straight from the register flops
	assign limit_fields = limit_word;
	assign loop_fields = loop_word;
endmodule

// >>> verification/clcr_regs_sva.sv
// Assertion checker for the limit and loop resistor register pair
`timescale 1ns/1ps
module clcr_regs_chk
(
	// Clock and reset
	input logic ref_clk,
	input logic resetn,
	// Register access
	input logic [7:0] reg_addr,
	input logic reg_wr,
	input logic [7:0] reg_wdata,
	input logic reg_rd,
	input logic [7:0] reg_rdata,
	input logic reg_hit,
	// Fields and decode
	input clcr_pkg::clcr_limit_t limit_fields,
	input clcr_pkg::clcr_loop_t loop_fields,
	input clcr_pkg::clcr_ctrl_t ctrl
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	// A write then the decode stage; decode is judged on the data written
	sequence s_lim;
		reg_wr && reg_addr == 8'h05 ##1 1'b1;
	endsequence
	sequence s_loop;
		reg_wr && reg_addr == 8'h06 ##1 1'b1;
	endsequence
	property p_mode; s_lim |=> ctrl.forced_continuous == $past(reg_wdata[7], 2); endproperty
	a_mode: assert property (p_mode) else $error("mode decode wrong");
	property p_rev; s_lim |=> ctrl.reverse_limit_da == ($past(reg_wdata[7:6], 2) == 2'b11 ? 6'h2f
		: $past(reg_wdata[7:6], 2) == 2'b10 ? 6'h19 : 6'h00); endproperty
	a_rev: assert property (p_rev) else $error("reverse limit wrong");
	property p_dcm; (reg_wr && reg_addr == 8'h05 && !reg_wdata[7]) ##1 1'b1 |=> !ctrl.reverse_limit_en; endproperty
	a_dcm: assert property (p_dcm) else $error("reverse limit active in DCM");
	property p_val; s_lim |=> ctrl.valley_limit_a == {1'b0, $past(reg_wdata[5:3], 2)} + 4'h1; endproperty
	a_val: assert property (p_val) else $error("valley limit wrong");
	property p_vld; s_lim |=> ctrl.valley_limit_valid == ($past(reg_wdata[5:3], 2) <= {1'b0, $past(reg_wdata[2:0], 2)} + 4'h1);
	endproperty
	a_vld: assert property (p_vld) else $error("valley valid wrong");
	property p_pk; s_lim |=> ctrl.peak_limit_a == {1'b0, $past(reg_wdata[2:0], 2)} + 4'h2; endproperty
	a_pk: assert property (p_pk) else $error("peak limit wrong");
	property p_fb; s_loop |=> ctrl.feedback_res_k == 10'h032 + 10'h01e * $past(reg_wdata[7:5], 2); endproperty
	a_fb: assert property (p_fb) else $error("feedback resistor wrong");
	property p_rc; (reg_wr && reg_addr == 8'h06 && reg_wdata[4:0] == 5'h1f) ##1 1'b1 |=> ctrl.loop_res_k == 12'hf25;
	endproperty
	a_rc: assert property (p_rc) else $error("top loop resistor wrong");
	property p_wr; reg_wr && reg_addr == 8'h06 |=> loop_fields == $past(reg_wdata); endproperty
	a_wr: assert property (p_wr) else $error("write not stored");
	property p_wr_lim; reg_wr && reg_addr == 8'h05 |=> limit_fields == $past(reg_wdata); endproperty
	a_wr_lim: assert property (p_wr_lim) else $error("limit write not stored");
	// Unmapped writes must leave both registers alone
	property p_unmap; reg_wr && reg_addr != 8'h05 && reg_addr != 8'h06 |=> $stable(limit_fields) && $stable(loop_fields);
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped write changed a register");
	property p_hit; reg_hit == (reg_addr == 8'h05 || reg_addr == 8'h06); endproperty
	a_hit: assert property (p_hit) else $error("address hit flag wrong");
	property p_rd; reg_rd |=> reg_rdata == ($past(reg_addr) == 8'h05 ? $past(limit_fields)
		: $past(reg_addr) == 8'h06 ? $past(loop_fields) : 8'h00); endproperty
	a_rd: assert property (p_rd) else $error("read data wrong");
endmodule
bind clcr_regs clcr_regs_chk chk (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
	.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .limit_fields(limit_fields),
	.loop_fields(loop_fields), .ctrl(ctrl));

// >>> verification/clcr_regs_tb.sv
// Self-checking bench for the limit and loop resistor register pair
`timescale 1ns/1ps
module clcr_regs_tb;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic reg_wr = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic reg_hit;
	logic rd_seen = 1'b0;
	logic [31:0] seed = 32'h78073d48;
	logic [7:0] shadow [2] = '{8'h00, 8'h00};
	logic [7:0] exp_q [$];
	int bad_count = 0;
	int samples_checked = 0;
	clcr_pkg::clcr_limit_t limit_fields;
	clcr_pkg::clcr_loop_t loop_fields;
	clcr_pkg::clcr_ctrl_t ctrl;
	clcr_regs dut (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .limit_fields(limit_fields),
		.loop_fields(loop_fields), .ctrl(ctrl));
	always #2.5 ref_clk = ~ref_clk;
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
		samples_checked++;
		if (seen !== want)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, want, seen);
		end
	endtask
	// Strobes stay up across back-to-back calls; the shadow predicts read data
	task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= wr;
		reg_rd <= !wr;
		reg_addr <= a;
		reg_wdata <= d;
		if (!wr)
			exp_q.push_back((a == 8'h05 || a == 8'h06) ? shadow[a[1]] : 8'h00);
		else if (a == 8'h05 || a == 8'h06)
			shadow[a[1]] = d;
	endtask
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Read data lands one edge after the read strobe
	always @(posedge ref_clk)
	begin
		rd_seen <= reg_rd;
		if (rd_seen)
			check("reg_rdata", reg_rdata, exp_q.pop_front());
	end
	initial
	begin
		#20000;
		bad_count++;
		finish_test();
	end
	// Reset values, random mixed traffic with unmapped places, then table ends
	initial
	begin
		repeat (10) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge ref_clk);
		access(1'b0, 8'h05, 8'h00);
		access(1'b0, 8'h06, 8'h00);
		for (int i = 0; i < 300; i++)
		begin
			seed = xs(seed);
			access(seed[8], seed[10:9] == 2'b00 ? seed[23:16] : (seed[9] ? 8'h05 : 8'h06), seed[7:0]);
		end
		// Mid-run reset: strobes down, last read checked, then both registers back to reset values
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b0;
		shadow = '{8'h00, 8'h00};
		repeat (3) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge ref_clk);
		access(1'b0, 8'h05, 8'h00);
		access(1'b0, 8'h06, 8'h00);
		access(1'b1, 8'h06, 8'hff);
		access(1'b0, 8'h06, 8'h00);
		access(1'b1, 8'h06, 8'h00);
		access(1'b0, 8'h06, 8'h00);
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		repeat (4) @(posedge ref_clk);
		finish_test();
	end
endmodule
